// ---- hdl/pattern_out_regs.svh ----
// register indices, reset values and field positions of the pattern output staging block
`ifndef PATTERN_OUT_REGS_SVH
`define PATTERN_OUT_REGS_SVH

// register indices: byte address is four times the index
`define PO_IDX_HI_FIRST 16'hffa4
`define PO_IDX_LO_FIRST 16'hffa5
`define PO_IDX_HI_SECOND 16'hffa6
`define PO_IDX_LO_SECOND 16'hffa7
`define PO_IDX_TSEL 16'hffa0
`define PO_IDX_EN_HI 16'hffa1
`define PO_IDX_EN_LO 16'hffa2
`define PO_IDX_PORT_LO 16'hffa8
`define PO_IDX_PORT_HI 16'hffa9

// address fields
`define PO_IDX_MSB 17
`define PO_IDX_LSB 2
`define PO_TOP_MSB 31
`define PO_TOP_LSB 18
`define PO_ADDR_TOP 14'h0000

// reset values, fixed read values and the okay response
`define PO_EN_RST 8'h00
`define PO_STAGE_RST 8'h00
`define PO_PORT_RST 8'h00
`define PO_TSEL_RST 8'hff
`define PO_RSVD_ONES 4'hf
`define PO_RSVD_BYTE 8'hff
`define PO_RD_PAD 24'h00_0000
`define PO_UNMAPPED 32'h0000_0000
`define PO_RESP_OKAY 1'b0

// bus and data fields
`define PO_HTRANS_ACTIVE 1
`define PO_BYTE_MSB 7
`define PO_NIB_UP_LSB 4
`define PO_NIB_LO_MSB 3
`define PO_SEL_W 2
`define PO_G0_SEL_MSB 1

`endif

// ---- hdl/pattern_out_pkg.sv ----
// types shared by the pattern output staging block
package pattern_out_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [1:0] trig_sel_t;

  // whole state of the top module
  typedef struct packed {
    byte_t [1:0] en;
    byte_t [1:0] stage;
    byte_t [1:0] port;
    byte_t tsel;
    logic dph_wr;
    logic [15:0] dph_idx;
    logic [31:0] rdata;
  } state_t;

endpackage

// ---- hdl/nibble_pair_transfer.sv ----
// staging byte view and enabled-bit transfer for one pair of four-pin groups
`timescale 1ns/100ps
`default_nettype none
`include "pattern_out_regs.svh"

module nibble_pair_transfer
  import pattern_out_pkg::*;
(
  input wire logic [7:0] stage,
  input wire logic [7:0] en,
  input wire logic [7:0] port,
  input wire logic [1:0] sel_up,
  input wire logic [1:0] sel_lo,
  input wire logic [3:0] cmp_match,
  input wire logic wr_first,
  input wire logic wr_second,
  input wire logic wr_port,
  input wire logic [7:0] wdata,
  output logic [7:0] stage_nxt,
  output logic [7:0] port_nxt,
  output logic [7:0] rd_first,
  output logic [7:0] rd_second,
  output logic [7:0] xfer_mask,
  output logic shared
);

  logic fire_up;
  logic fire_lo;
  logic [7:0] sw_port;

  assign shared = (sel_up == sel_lo);
  assign fire_up = cmp_match[sel_up];
  assign fire_lo = cmp_match[sel_lo];
  // only enabled bits of a fired group move
  assign xfer_mask = {{4{fire_up}}, {4{fire_lo}}} & en;
  // enabled bits ignore software writes
  assign sw_port = wr_port ? ((port & en) | (wdata & ~en)) : port;
  assign port_nxt = (xfer_mask & stage) | (~xfer_mask & sw_port);

  always_comb
  begin
    stage_nxt = stage;
    if (wr_first)
    begin
      if (shared)
      begin
        stage_nxt = wdata;
      end
      else
      begin
        stage_nxt[`PO_BYTE_MSB:`PO_NIB_UP_LSB] = wdata[`PO_BYTE_MSB:`PO_NIB_UP_LSB];
      end
    end
    if (wr_second && !shared)
    begin
      stage_nxt[`PO_NIB_LO_MSB:0] = wdata[`PO_NIB_LO_MSB:0];
    end
  end

  assign rd_first = shared ? stage : {stage[`PO_BYTE_MSB:`PO_NIB_UP_LSB], `PO_RSVD_ONES};
  assign rd_second = shared ? `PO_RSVD_BYTE : {`PO_RSVD_ONES, stage[`PO_NIB_LO_MSB:0]};

endmodule
`default_nettype wire

// ---- hdl/pattern_output_next_data_enable.sv ----
// pattern output next-data staging, per-pin enables and port data with an AHB-Lite slave
//
// Behaviour
// - split triggers: group 3 nibble upper, ones below
// - split triggers: group 2 nibble second, ones above
// - low enable register, one bit per pin
// - enabled low pins copy staging on trigger
// - disabled low pins keep their port value
// - low enables clear on reset and standby
// - high enable register, one bit per pin
// - enabled high pins copy staging on trigger
// - disabled high pins keep their port value
// - high enables clear on reset and standby
// - enabled port bits ignore software writes
// - two-bit select picks timer channel, reset three
// - shared trigger: whole byte first, second reads ones
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pattern_out_regs.svh"

module pattern_output_next_data_enable
  import pattern_out_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclken,
  input wire logic hw_standby,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] cmp_match,
  output logic [7:0] low_port_output_data,
  output logic [7:0] high_port_output_data
);

  // ****************************************
  // reset constant
  // ****************************************

  localparam state_t STATE_RST = '{
    en: {`PO_EN_RST, `PO_EN_RST},
    stage: {`PO_STAGE_RST, `PO_STAGE_RST},
    port: {`PO_PORT_RST, `PO_PORT_RST},
    tsel: `PO_TSEL_RST,
    dph_wr: 1'b0,
    dph_idx: 16'h0000,
    rdata: `PO_UNMAPPED
  };

  state_t state_r;
  state_t state_nxt;

  byte_t [1:0] stage_n;
  byte_t [1:0] port_n;
  byte_t [1:0] rd_first;
  byte_t [1:0] rd_second;
  byte_t [1:0] xmask;
  logic [1:0] wr_first;
  logic [1:0] wr_second;
  logic [1:0] wr_port;
  logic [1:0] wr_en;
  logic [1:0] shared;
  logic wr_tsel;
  logic dph_we;
  logic take;
  logic addr_ok;
  logic [15:0] aidx;
  logic [31:0] rd_val;

  // ****************************************
  // bus address phase
  // ****************************************

  // wait states only while the clock enable freezes the block
  assign hreadyout = hclken;
  assign hresp = `PO_RESP_OKAY;
  assign hrdata = state_r.rdata;

  assign take = hsel && hready && htrans[`PO_HTRANS_ACTIVE];
  assign aidx = haddr[`PO_IDX_MSB:`PO_IDX_LSB];
  assign addr_ok = (haddr[`PO_TOP_MSB:`PO_TOP_LSB] == `PO_ADDR_TOP);
  assign dph_we = state_r.dph_wr;
  assign wr_tsel = dph_we && (state_r.dph_idx == `PO_IDX_TSEL);

  // ****************************************
  // per byte staging and transfer
  // ****************************************

  for (genvar g = 0; g < 2; g++)
  begin : g_pair
    localparam logic [15:0] IDX_FIRST = (g == 1) ? `PO_IDX_HI_FIRST : `PO_IDX_LO_FIRST;
    localparam logic [15:0] IDX_SECOND = (g == 1) ? `PO_IDX_HI_SECOND : `PO_IDX_LO_SECOND;
    localparam logic [15:0] IDX_EN = (g == 1) ? `PO_IDX_EN_HI : `PO_IDX_EN_LO;
    localparam logic [15:0] IDX_PORT = (g == 1) ? `PO_IDX_PORT_HI : `PO_IDX_PORT_LO;

    assign wr_first[g] = dph_we && (state_r.dph_idx == IDX_FIRST);
    assign wr_second[g] = dph_we && (state_r.dph_idx == IDX_SECOND);
    assign wr_en[g] = dph_we && (state_r.dph_idx == IDX_EN);
    assign wr_port[g] = dph_we && (state_r.dph_idx == IDX_PORT);

    nibble_pair_transfer u_pair (
      .stage(state_r.stage[g]),
      .en(state_r.en[g]),
      .port(state_r.port[g]),
      .sel_up(state_r.tsel[4*g+3 -: `PO_SEL_W]),
      .sel_lo(state_r.tsel[4*g+1 -: `PO_SEL_W]),
      .cmp_match(cmp_match),
      .wr_first(wr_first[g]),
      .wr_second(wr_second[g]),
      .wr_port(wr_port[g]),
      .wdata(hwdata[`PO_BYTE_MSB:0]),
      .stage_nxt(stage_n[g]),
      .port_nxt(port_n[g]),
      .rd_first(rd_first[g]),
      .rd_second(rd_second[g]),
      .xfer_mask(xmask[g]),
      .shared(shared[g])
    );
  end

  // ****************************************
  // read data select
  // ****************************************

  always_comb
  begin
    rd_val = `PO_UNMAPPED;
    if (addr_ok)
    begin
      case (aidx)
        `PO_IDX_LO_FIRST:
        begin
          rd_val = {`PO_RD_PAD, rd_first[0]};
        end
        `PO_IDX_LO_SECOND:
        begin
          rd_val = {`PO_RD_PAD, rd_second[0]};
        end
        `PO_IDX_HI_FIRST:
        begin
          rd_val = {`PO_RD_PAD, rd_first[1]};
        end
        `PO_IDX_HI_SECOND:
        begin
          rd_val = {`PO_RD_PAD, rd_second[1]};
        end
        `PO_IDX_EN_LO:
        begin
          rd_val = {`PO_RD_PAD, state_r.en[0]};
        end
        `PO_IDX_EN_HI:
        begin
          rd_val = {`PO_RD_PAD, state_r.en[1]};
        end
        `PO_IDX_TSEL:
        begin
          rd_val = {`PO_RD_PAD, state_r.tsel};
        end
        `PO_IDX_PORT_LO:
        begin
          rd_val = {`PO_RD_PAD, state_r.port[0]};
        end
        `PO_IDX_PORT_HI:
        begin
          rd_val = {`PO_RD_PAD, state_r.port[1]};
        end
        default:
        begin
          rd_val = `PO_UNMAPPED;
        end
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************

  always_comb
  begin
    state_nxt = state_r;
    if (hclken)
    begin
      if (hw_standby)
      begin
        state_nxt = STATE_RST;
      end
      else
      begin
        state_nxt.stage = stage_n;
        state_nxt.port = port_n;
        if (wr_en[0])
        begin
          state_nxt.en[0] = hwdata[`PO_BYTE_MSB:0];
        end
        if (wr_en[1])
        begin
          state_nxt.en[1] = hwdata[`PO_BYTE_MSB:0];
        end
        if (wr_tsel)
        begin
          state_nxt.tsel = hwdata[`PO_BYTE_MSB:0];
        end
        state_nxt.dph_wr = take && hwrite && addr_ok;
        state_nxt.dph_idx = aidx;
        if (take && !hwrite)
        begin
          state_nxt.rdata = rd_val;
        end
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= STATE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign low_port_output_data = state_r.port[0];
  assign high_port_output_data = state_r.port[1];

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge hclk);
  endclocking

  default disable iff (!hresetn);

  sequence s_run;
    hclken && !hw_standby;
  endsequence

  sequence s_rd_hi(logic [15:0] idx, logic sh);
    s_run ##0 (take && !hwrite && addr_ok && aidx == idx && shared[1] == sh);
  endsequence

  AST_EN_CLEAR: assert property (
    (hclken && hw_standby) |=> (state_r.en[0] == `PO_EN_RST && state_r.en[1] == `PO_EN_RST))
    else $error("enables not cleared by hardware standby");

  AST_EN_LO_WRITE: assert property (
    (s_run ##0 wr_en[0]) |=> state_r.en[0] == $past(hwdata[`PO_BYTE_MSB:0]))
    else $error("low enable write lost");

  AST_EN_HI_WRITE: assert property (
    (s_run ##0 wr_en[1]) |=> state_r.en[1] == $past(hwdata[`PO_BYTE_MSB:0]))
    else $error("high enable write lost");

  AST_LO_COPY: assert property (
    (s_run ##0 xmask[0] != 8'h00)
      |=> ((state_r.port[0] ^ $past(state_r.stage[0])) & $past(xmask[0])) == 8'h00)
    else $error("enabled low bit not copied on trigger");

  AST_HI_COPY: assert property (
    (s_run ##0 xmask[1] != 8'h00)
      |=> ((state_r.port[1] ^ $past(state_r.stage[1])) & $past(xmask[1])) == 8'h00)
    else $error("enabled high bit not copied on trigger");

  AST_LO_HOLD: assert property (
    (s_run ##0 !wr_port[0])
      |=> ((state_r.port[0] ^ $past(state_r.port[0])) & ~$past(state_r.en[0])) == 8'h00)
    else $error("disabled low bit changed");

  AST_HI_HOLD: assert property (
    (s_run ##0 !wr_port[1])
      |=> ((state_r.port[1] ^ $past(state_r.port[1])) & ~$past(state_r.en[1])) == 8'h00)
    else $error("disabled high bit changed");

  AST_PORT_RO: assert property (
    (s_run ##0 (wr_port[0] && xmask[0] == 8'h00))
      |=> ((state_r.port[0] ^ $past(state_r.port[0])) & $past(state_r.en[0])) == 8'h00)
    else $error("software write changed an enabled port bit");

  AST_TRIG_SEL: assert property (
    (s_run ##0 (state_r.en[1] == 8'hff && cmp_match[state_r.tsel[`PO_BYTE_MSB -: `PO_SEL_W]]))
      |=> state_r.port[1][`PO_BYTE_MSB:`PO_NIB_UP_LSB]
        == $past(state_r.stage[1][`PO_BYTE_MSB:`PO_NIB_UP_LSB]))
    else $error("selected channel did not trigger group 3");

  AST_SPLIT_UPPER: assert property (
    s_rd_hi(`PO_IDX_HI_FIRST, 1'b0)
      |=> (hrdata[3:0] == `PO_RSVD_ONES && hrdata[7:4] == $past(state_r.stage[1][7:4])))
    else $error("split upper address reads wrong");

  AST_SPLIT_LOWER: assert property (
    s_rd_hi(`PO_IDX_HI_SECOND, 1'b0)
      |=> (hrdata[7:4] == `PO_RSVD_ONES && hrdata[3:0] == $past(state_r.stage[1][3:0])))
    else $error("split second address reads wrong");

  AST_SHARED: assert property (
    s_rd_hi(`PO_IDX_HI_SECOND, 1'b1) |=> hrdata[7:0] == `PO_RSVD_BYTE)
    else $error("shared second address not all ones");

  AST_SHARED_UPPER: assert property (
    s_rd_hi(`PO_IDX_HI_FIRST, 1'b1) |=> hrdata[`PO_BYTE_MSB:0] == $past(state_r.stage[1]))
    else $error("shared upper address not the whole byte");

  AST_LO_TRIG_SEL: assert property (
    (s_run ##0 cmp_match[state_r.tsel[`PO_G0_SEL_MSB:0]])
      |=> ((state_r.port[0][`PO_NIB_LO_MSB:0] ^ $past(state_r.stage[0][`PO_NIB_LO_MSB:0]))
        & $past(state_r.en[0][`PO_NIB_LO_MSB:0])) == 4'h0)
    else $error("selected channel did not trigger group 0");

  AST_EN_LO_KEEP: assert property (
    (s_run ##0 !wr_en[0]) |=> state_r.en[0] == $past(state_r.en[0]))
    else $error("low enable changed without a write");

  AST_EN_HI_KEEP: assert property (
    (s_run ##0 !wr_en[1]) |=> state_r.en[1] == $past(state_r.en[1]))
    else $error("high enable changed without a write");

  AST_STANDBY_CLEAR: assert property (
    (hclken && hw_standby)
      |=> (state_r.tsel == `PO_TSEL_RST && state_r.port == {`PO_PORT_RST, `PO_PORT_RST}
        && state_r.stage == {`PO_STAGE_RST, `PO_STAGE_RST}))
    else $error("standby left select, port or staging set");

  AST_FREEZE: assert property (
    !hclken |=> state_r == $past(state_r))
    else $error("state changed while clock enable low");

  AST_BUS_OKAY: assert property (
    hresp == `PO_RESP_OKAY && hreadyout == hclken)
    else $error("bus response not okay or ready not following enable");

endmodule
`default_nettype wire

// ---- sim/timer_match_model.sv ----
// timer stand-in that emits single-cycle compare-match pulses
`timescale 1ns/100ps
`default_nettype none
module timer_match_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fire,
  input wire logic [1:0] ch,
  input wire logic [1:0] dly,
  output logic [3:0] cmp_match
);
  logic [1:0] cnt_r;
  logic [1:0] ch_r;
  logic pend_r;
  // pulse lasts one cycle, after a wait of dly cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= 2'h0;
      ch_r <= 2'h0;
      pend_r <= 1'b0;
      cmp_match <= 4'h0;
    end
    else
    begin
      if (fire)
      begin
        cnt_r <= dly;
        ch_r <= ch;
        pend_r <= 1'b1;
        cmp_match <= 4'h0;
      end
      else if (pend_r && cnt_r == 2'h0)
      begin
        cmp_match <= 4'h1 << ch_r;
        pend_r <= 1'b0;
      end
      else
      begin
        cmp_match <= 4'h0;
        if (pend_r)
        begin
          cnt_r <= cnt_r - 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/pattern_output_next_data_enable_test.sv ----
// self-checking bench for the pattern output staging block
`timescale 1ns/100ps
`default_nettype none
`include "pattern_out_regs.svh"
module pattern_output_next_data_enable_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hclken = 1'b1;
  logic hw_standby = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] cmp_match;
  logic [7:0] low_port_output_data;
  logic [7:0] high_port_output_data;
  logic fire = 1'b0;
  logic [1:0] mch = 2'h0;
  logic [1:0] mdly = 2'h0;
  logic [7:0] en [2];
  logic [7:0] st [2];
  logic [7:0] pt [2];
  logic [7:0] tsel;
  logic [31:0] rq [$];
  logic [15:0] pq [$];
  logic rd_ph = 1'b0;
  logic mt_ph = 1'b0;
  int err_count = 0;
  int checked = 0;
  always #12.5 hclk = ~hclk;
  pattern_output_next_data_enable pattern_output_next_data_enable_i (.hclk(hclk),
    .hresetn(hresetn), .hclken(hclken), .hw_standby(hw_standby), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_match(cmp_match),
    .low_port_output_data(low_port_output_data), .high_port_output_data(high_port_output_data));
  timer_match_model timer_match_model_i (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .ch(mch), .dly(mdly), .cmp_match(cmp_match));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic split(input logic p);
    return p ? (tsel[7:6] != tsel[5:4]) : (tsel[3:2] != tsel[1:0]);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [15:0] idx);
    logic p;
    logic [7:0] v;
    p = ~idx[0];
    case (idx)
      `PO_IDX_TSEL: v = tsel;
      `PO_IDX_EN_HI: v = en[1];
      `PO_IDX_EN_LO: v = en[0];
      `PO_IDX_PORT_LO: v = pt[0];
      `PO_IDX_PORT_HI: v = pt[1];
      `PO_IDX_HI_FIRST, `PO_IDX_LO_FIRST: v = split(p) ? {st[p][7:4], 4'hf} : st[p];
      `PO_IDX_HI_SECOND, `PO_IDX_LO_SECOND: v = split(p) ? {4'hf, st[p][3:0]} : 8'hff;
      default: v = 8'h00;
    endcase
    return {24'h00_0000, v};
  endfunction
  // ****************
  // bus master tasks
  // ****************
  task xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [15:0] idx);
    rq.push_back(exp_rd(idx));
    xfer(1'b0, idx, 8'h00);
  endtask
  task wr(input logic [15:0] idx, input logic [7:0] d);
    logic p;
    p = ~idx[0];
    case (idx)
      `PO_IDX_TSEL: tsel = d;
      `PO_IDX_EN_HI: en[1] = d;
      `PO_IDX_EN_LO: en[0] = d;
      `PO_IDX_PORT_LO: pt[0] = (pt[0] & en[0]) | (d & ~en[0]);
      `PO_IDX_PORT_HI: pt[1] = (pt[1] & en[1]) | (d & ~en[1]);
      `PO_IDX_HI_FIRST, `PO_IDX_LO_FIRST: st[p] = split(p) ? {d[7:4], st[p][3:0]} : d;
      `PO_IDX_HI_SECOND, `PO_IDX_LO_SECOND: if (split(p)) st[p][3:0] = d[3:0];
      default: ;
    endcase
    xfer(1'b1, idx, d);
  endtask
  task trig(input logic [1:0] ch, input logic [1:0] dly);
    logic [15:0] m;
    m = 16'h0000;
    for (int g = 0; g < 4; g++)
      if (tsel[2*g +: 2] == ch) m[4*g +: 4] = 4'hf;
    m = m & {en[1], en[0]};
    {pt[1], pt[0]} = ({pt[1], pt[0]} & ~m) | ({st[1], st[0]} & m);
    pq.push_back({pt[1], pt[0]});
    fire <= 1'b1;
    mch <= ch;
    mdly <= dly;
    @(posedge hclk);
    fire <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask
  task clr_model();
    en = '{8'h00, 8'h00};
    st = '{8'h00, 8'h00};
    pt = '{8'h00, 8'h00};
    tsel = 8'hff;
  endtask
  // read data and port values compared when they appear
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout === 1'b1)
    begin
      check("hrdata", hrdata, rq.pop_front());
      check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
    end
    if (mt_ph)
      check("port", {16'h0000, high_port_output_data, low_port_output_data}, pq.pop_front());
    // a read whose data phase is stretched stays pending until ready
    rd_ph = (rd_ph && hreadyout !== 1'b1) || (hsel && htrans[1] && !hwrite && hreadyout);
    mt_ph = |cmp_match;
  end
  initial
  begin
    repeat (4000) @(posedge hclk);
    err_count++;
    wrap_up();
  end
  // ****************
  // test sequence
  // ****************
  initial
  begin
    void'($urandom(8));
    clr_model();
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`PO_IDX_EN_LO);
    rd(`PO_IDX_EN_HI);
    rd(`PO_IDX_TSEL);
    rd(`PO_IDX_HI_FIRST);
    rd(`PO_IDX_HI_SECOND);
    rd(16'hffb3);
    $display("test reset values done");
    wr(`PO_IDX_TSEL, 8'h1b);
    wr(`PO_IDX_EN_HI, 8'hff);
    wr(`PO_IDX_HI_FIRST, 8'ha5);
    wr(`PO_IDX_HI_SECOND, 8'h3c);
    rd(`PO_IDX_HI_FIRST);
    rd(`PO_IDX_HI_SECOND);
    trig(2'h0, 2'h0);
    trig(2'h1, 2'h3);
    $display("test split trigger done");
    for (int i = 0; i < 12; i++)
    begin
      wr(`PO_IDX_TSEL, 8'($urandom));
      wr(`PO_IDX_EN_LO, 8'($urandom));
      wr(`PO_IDX_EN_HI, 8'($urandom));
      wr(`PO_IDX_PORT_LO, 8'($urandom));
      wr(`PO_IDX_PORT_HI, 8'($urandom));
      wr(`PO_IDX_HI_FIRST, 8'($urandom));
      wr(`PO_IDX_LO_SECOND, 8'($urandom));
      rd(`PO_IDX_EN_LO);
      rd(`PO_IDX_EN_HI);
      rd(`PO_IDX_PORT_LO);
      rd(`PO_IDX_PORT_HI);
      rd(`PO_IDX_LO_FIRST);
      rd(`PO_IDX_HI_FIRST);
      rd(`PO_IDX_HI_SECOND);
      trig(2'(i), 2'($urandom));
    end
    $display("test random triggers done");
    wr(`PO_IDX_TSEL, 8'he4);
    // clock enable drops across the data phase of the enable write
    fork
      wr(`PO_IDX_EN_LO, 8'hff);
      begin
        @(posedge hclk);
        hclken <= 1'b0;
        repeat (3) @(posedge hclk);
        hclken <= 1'b1;
      end
    join
    wr(`PO_IDX_LO_FIRST, 8'h96);
    wr(`PO_IDX_LO_SECOND, 8'h96);
    rd(`PO_IDX_EN_LO);
    rd(`PO_IDX_LO_SECOND);
    trig(2'h0, 2'h1);
    trig(2'h1, 2'h2);
    $display("test clock enable and low groups done");
    hw_standby <= 1'b1;
    @(posedge hclk);
    hw_standby <= 1'b0;
    clr_model();
    rd(`PO_IDX_EN_LO);
    rd(`PO_IDX_EN_HI);
    rd(`PO_IDX_TSEL);
    rd(`PO_IDX_PORT_LO);
    rd(`PO_IDX_LO_FIRST);
    $display("test hardware standby done");
    wr(`PO_IDX_EN_LO, 8'hc3);
    wr(`PO_IDX_EN_HI, 8'h3c);
    wr(`PO_IDX_TSEL, 8'h00);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    clr_model();
    rd(`PO_IDX_EN_LO);
    rd(`PO_IDX_EN_HI);
    rd(`PO_IDX_TSEL);
    $display("test mid-run reset done");
    repeat (2) @(posedge hclk);
    wrap_up();
  end
endmodule
`default_nettype wire
